/* bai_params.svh */
// Constants for the byte add instruction unit
`ifndef BAI_PARAMS_SVH
`define BAI_PARAMS_SVH
`define BAI_OP_LIT 8'h0F
`define BAI_OP_ADD 6'h09
`define BAI_OP_ADDC 6'h08
`define BAI_D_BIT 9
`define BAI_A_BIT 8
`define BAI_IDX_MAX 8'h5F
`define BAI_ACCESS_SPLIT 8'h80
`define BAI_LOW_BANK 4'h0
`define BAI_HIGH_BANK 4'hF
`define BAI_W_RST 8'h00
`define BAI_FLAGS_RST 5'h00
`define BAI_PHASES 4
`endif

/* bai_pkg.sv */
// Types shared by the byte add instruction unit
package bai_pkg;
  typedef enum logic [1:0] {
    BAI_NONE,
    BAI_LIT,
    BAI_ADD,
    BAI_ADDC
  } bai_op_t;
  typedef enum logic [2:0] {
    BAI_IDLE,
    BAI_DECODE,
    BAI_READ,
    BAI_PROCESS,
    BAI_WRITE
  } bai_phase_t;
  typedef struct packed {
    logic neg;
    logic signed_wrap_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } bai_flags_t;
endpackage

/* bai_mem_if.sv */
// Data memory port between the add unit and its register file
`timescale 1ns/1ps
`default_nettype none
interface bai_mem_if #(parameter int ADDR_W = 12);
  logic [ADDR_W-1:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

/* bai_data_mem.sv */
// Byte-wide data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module bai_data_mem #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_in,
  bai_mem_if.mem port
);
  logic [7:0] store [0:(1<<ADDR_W)-1];
  logic [7:0] rdata_q;

  // Read returns the old byte on a same-cycle write
  always_ff @(posedge clk_in) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    rdata_q <= store[port.addr];
  end

  assign port.rdata = rdata_q;
endmodule // bai_data_mem
`default_nettype wire

/* bai_add_unit.sv */
// Byte add instruction unit: decode, operand fetch, add, write back
`timescale 1ns/1ps
`default_nettype none
`include "bai_params.svh"
module bai_add_unit #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [15:0] instr_in,
  input wire logic ext_set_in,
  input wire logic [3:0] bank_pointer_register_in,
  input wire logic [ADDR_W-1:0] index_base_in,
  input wire logic load_we_in,
  input wire logic [ADDR_W-1:0] load_addr_in,
  input wire logic [7:0] load_data_in,
  output logic busy_out,
  output logic done_out,
  output logic illegal_out,
  output logic [7:0] w_out,
  output bai_pkg::bai_flags_t flags_out,
  output logic [7:0] mem_rdata_out
);
  import bai_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  function automatic bai_op_t decode_op(input logic [15:0] word);
    if (word[15:8] == `BAI_OP_LIT) begin
      decode_op = BAI_LIT;
    end else if (word[15:10] == `BAI_OP_ADD) begin
      decode_op = BAI_ADD;
    end else if (word[15:10] == `BAI_OP_ADDC) begin
      decode_op = BAI_ADDC;
    end else begin
      decode_op = BAI_NONE;
    end
  endfunction

  // Returns {carry, half carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    add8 = {full[8], low[4], full[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  bai_mem_if #(.ADDR_W(ADDR_W)) mem_bus ();

  bai_data_mem #(.ADDR_W(ADDR_W)) u_mem (
    .clk_in(clk_in),
    .port(mem_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////
  // Phase sequencer: one instruction cycle is four clocks
  bai_phase_t phase_q, phase_d;
  logic [15:0] instr_q, instr_d;
  bai_op_t op;

  always_comb begin
    phase_d = phase_q;
    instr_d = instr_q;
    case (phase_q)
      BAI_IDLE: begin
        if (start_in) begin
          phase_d = BAI_DECODE;
          instr_d = instr_in;
        end
      end
      BAI_DECODE: phase_d = BAI_READ;
      BAI_READ: phase_d = BAI_PROCESS;
      BAI_PROCESS: phase_d = BAI_WRITE;
      BAI_WRITE: phase_d = BAI_IDLE;
      default: phase_d = BAI_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_q <= BAI_IDLE;
      instr_q <= 16'h0000;
    end else begin
      phase_q <= phase_d;
      instr_q <= instr_d;
    end
  end

  assign op = decode_op(instr_q);
  assign busy_out = (phase_q != BAI_IDLE);
  assign done_out = (phase_q == BAI_WRITE);
  assign illegal_out = (phase_q == BAI_WRITE) && (op == BAI_NONE);

  ////////////////////////////////////////////////////////////////////////
  // Operand address resolution
  logic [7:0] f_addr;
  logic dest_reg;
  logic bank_sel;
  logic [ADDR_W-1:0] eff_addr;

  assign f_addr = instr_q[7:0];
  assign dest_reg = instr_q[`BAI_D_BIT];
  assign bank_sel = instr_q[`BAI_A_BIT];

  always_comb begin
    if (bank_sel) begin
      eff_addr = ADDR_W'({bank_pointer_register_in, f_addr});
    end else if (ext_set_in && (f_addr <= `BAI_IDX_MAX)) begin
      // Indexed offset wraps within the memory, no bound check
      eff_addr = index_base_in + ADDR_W'(f_addr);
    end else if (f_addr < `BAI_ACCESS_SPLIT) begin
      eff_addr = ADDR_W'({`BAI_LOW_BANK, f_addr});
    end else begin
      eff_addr = ADDR_W'({`BAI_HIGH_BANK, f_addr});
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Datapath: working register, flags, sum
  logic [7:0] w_q, w_d;
  bai_flags_t flags_q, flags_d;
  logic [9:0] sum_q, sum_d;
  logic [7:0] operand;
  logic reg_op;

  assign reg_op = (op == BAI_ADD) || (op == BAI_ADDC);
  assign operand = (op == BAI_LIT) ? instr_q[7:0] : mem_bus.rdata;

  always_comb begin
    w_d = w_q;
    flags_d = flags_q;
    sum_d = sum_q;
    if (phase_q == BAI_PROCESS) begin
      sum_d = add8(w_q, operand,
                   (op == BAI_ADDC) && flags_q.carry);
    end
    if ((phase_q == BAI_WRITE) && (op != BAI_NONE)) begin
      flags_d.carry = sum_q[9];
      flags_d.half_carry_flag = sum_q[8];
      flags_d.zero = (sum_q[7:0] == 8'h00);
      flags_d.neg = sum_q[7];
      flags_d.signed_wrap_flag = (w_q[7] == operand[7]) &&
                                 (sum_q[7] != w_q[7]);
      if (!reg_op || !dest_reg) begin
        w_d = sum_q[7:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      w_q <= `BAI_W_RST;
      flags_q <= `BAI_FLAGS_RST;
      sum_q <= 10'h000;
    end else begin
      w_q <= w_d;
      flags_q <= flags_d;
      sum_q <= sum_d;
    end
  end

  // Memory write lands on the closing edge of the write phase
  assign mem_bus.addr = busy_out ? eff_addr : load_addr_in;
  assign mem_bus.we = busy_out ? ((phase_q == BAI_WRITE) && reg_op &&
                                  dest_reg) : load_we_in;
  assign mem_bus.wdata = busy_out ? sum_q[7:0] : load_data_in;
  assign mem_rdata_out = mem_bus.rdata;
  assign w_out = w_q;
  assign flags_out = flags_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_cycle_four_phases: assert property (
    (phase_q == BAI_IDLE && start_in) |=> (phase_q == BAI_DECODE)
      ##3 (phase_q == BAI_WRITE) ##1 (phase_q == BAI_IDLE))
    else $error("instruction did not take four phases");

  a_literal_to_w: assert property (
    (phase_q == BAI_WRITE && op == BAI_LIT) |=>
      w_q == $past(w_q) + $past(instr_q[7:0]))
    else $error("literal add wrote wrong value to w");

  a_reg_to_w: assert property (
    (phase_q == BAI_WRITE && op == BAI_ADD && !dest_reg) |=>
      w_q == $past(w_q) + $past(mem_bus.rdata))
    else $error("register add to w wrong");

  a_reg_to_mem: assert property (
    (phase_q == BAI_WRITE && reg_op && dest_reg) |->
      mem_bus.we && mem_bus.addr == eff_addr ##1 w_q == $past(w_q))
    else $error("register destination write missing");

  a_carry_add_sum: assert property (
    (phase_q == BAI_PROCESS && op == BAI_ADDC) |=>
      sum_q[7:0] == $past(w_q) + $past(mem_bus.rdata)
                    + {7'h00, $past(flags_q.carry)})
    else $error("carry add sum wrong");

  a_bank_select: assert property (
    (busy_out && bank_sel) |->
      mem_bus.addr == ADDR_W'({bank_pointer_register_in, f_addr}))
    else $error("bank pointer not used");

  a_indexed_addr: assert property (
    (busy_out && !bank_sel && ext_set_in && f_addr <= 8'h5F) |->
      mem_bus.addr == index_base_in + ADDR_W'(f_addr))
    else $error("indexed offset not used");

  a_zero_flag: assert property (
    (phase_q == BAI_WRITE && op != BAI_NONE) |=>
      flags_q.zero == ($past(sum_q[7:0]) == 8'h00) &&
      flags_q.neg == $past(sum_q[7]))
    else $error("zero or negative flag wrong");

  a_carry_flag: assert property (
    (phase_q == BAI_WRITE && op != BAI_NONE) |=>
      flags_q.carry == $past(sum_q[9]) &&
      flags_q.half_carry_flag == $past(sum_q[8]))
    else $error("carry flags wrong");

  a_illegal_quiet: assert property (
    (phase_q == BAI_WRITE && op == BAI_NONE) |->
      !mem_bus.we ##1 $stable(w_q) && $stable(flags_q))
    else $error("unknown opcode changed state");
endmodule // bai_add_unit
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench for the byte add instruction unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bai_pkg::*;
  logic [3:0] bank_ptr;
  logic [11:0] index_base;
  logic clk_in, rst_in, start_in, ext_set_in, load_we_in;
  logic [15:0] instr_in;
  logic [11:0] load_addr_in;
  logic [7:0] load_data_in, w_out, mem_rdata_out, w_m;
  logic busy_out, done_out, illegal_out;
  bai_flags_t flags_out;
  logic [4:0] f_m;
  logic [7:0] mem_m [0:4095];
  int n_mismatch, n_compared;
  logic [11:0] pa [8] = '{12'h012, 12'h344, 12'hF90, 12'h1FF, 12'h060,
                          12'h1B0, 12'h312, 12'h144};
  logic [7:0] pd [8] = '{8'hC2, 8'h81, 8'h7E, 8'hFF, 8'h01, 8'hF0, 8'h0F,
                         8'h5A};
  // Top bit of each entry enables the extended set
  // Last two entries run after the bank pointer and index base have moved
  logic [16:0] prog [17] = '{17'h00F10, 17'h00F15, 17'h00FDB, 17'h00F7F,
    17'h00F01, 17'h02412, 17'h02744, 17'h02690, 17'h1265F, 17'h12660,
    17'h12010, 17'h12210, 17'h02312, 17'h03000, 17'h0FFFF, 17'h02744,
    17'h12012};

  bai_add_unit #(.ADDR_W(12)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
    .instr_in(instr_in), .ext_set_in(ext_set_in),
    .bank_pointer_register_in(bank_ptr), .index_base_in(index_base),
    .load_we_in(load_we_in), .load_addr_in(load_addr_in),
    .load_data_in(load_data_in), .busy_out(busy_out),
    .done_out(done_out), .illegal_out(illegal_out), .w_out(w_out),
    .flags_out(flags_out), .mem_rdata_out(mem_rdata_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic poke(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    load_we_in <= 1'b1;
    load_addr_in <= a;
    load_data_in <= d;
    @(posedge clk_in);
    load_we_in <= 1'b0;
    mem_m[a] = d;
  endtask

  task automatic peek(input logic [11:0] a);
    @(posedge clk_in);
    load_addr_in <= a;
    @(posedge clk_in);
    #1;
    check({8'h00, mem_rdata_out}, {8'h00, mem_m[a]}, "memory byte");
  endtask

  // Drives one instruction, then mirrors its effect in the local model
  task automatic step(input logic [16:0] e);
    logic [15:0] ins;
    logic [7:0] fa, b, r;
    logic [11:0] ea;
    logic [8:0] s;
    logic [4:0] h;
    logic cin, lit, reg_op, bad;
    int k;
    ins = e[15:0];
    fa = ins[7:0];
    lit = ins[15:8] == 8'h0F;
    reg_op = ins[15:10] == 6'h09 || ins[15:10] == 6'h08;
    bad = !lit && !reg_op;
    if (ins[8]) ea = {bank_ptr, fa};
    else if (e[16] && fa <= 8'h5F) ea = index_base + {4'h0, fa};
    else ea = fa < 8'h80 ? {4'h0, fa} : {4'hF, fa};
    b = lit ? fa : mem_m[ea];
    cin = ins[15:10] == 6'h08 && f_m[0];
    s = {1'b0, w_m} + {1'b0, b} + {8'h00, cin};
    h = {1'b0, w_m[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r = s[7:0];
    @(posedge clk_in);
    ext_set_in <= e[16];
    start_in <= 1'b1;
    instr_in <= ins;
    @(posedge clk_in);
    // A second request while busy must be dropped
    instr_in <= 16'h0FFF;
    @(posedge clk_in);
    start_in <= 1'b0;
    k = 0;
    #1;
    while (done_out !== 1'b1 && k < 8) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    if (k == 8) begin
      n_mismatch++;
      $display("unexpected at %0t: no completion", $time);
      complete_run();
    end
    check(k[15:0], 16'h0002, "done cycle");
    check({15'h0, busy_out}, 16'h0001, "busy at write");
    check({15'h0, illegal_out}, {15'h0, bad}, "illegal flag");
    if (!bad) begin
      f_m = {r[7], (w_m[7] == b[7]) && (r[7] != w_m[7]), r == 8'h00, h[4],
             s[8]};
      if (lit || !ins[9]) w_m = r;
      else mem_m[ea] = r;
    end
    @(posedge clk_in);
    #1;
    check({15'h0, busy_out}, 16'h0000, "busy after");
    check({8'h00, w_out}, {8'h00, w_m}, "working register");
    check({11'h0, flags_out}, {11'h0, f_m}, "flags");
    if (reg_op && ins[9]) peek(ea);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst_in = 1'b1;
    start_in = 1'b0;
    ext_set_in = 1'b0;
    load_we_in = 1'b0;
    instr_in = 16'h0000;
    load_addr_in = 12'h000;
    load_data_in = 8'h00;
    bank_ptr = 4'h3;
    index_base = 12'h1A0;
    w_m = 8'h00;
    f_m = 5'h00;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    check({8'h00, w_out}, 16'h0000, "reset working register");
    check({11'h0, flags_out}, 16'h0000, "reset flags");
    check({15'h0, busy_out}, 16'h0000, "reset busy");
    $display("test reset ends");
    for (int i = 0; i < 8; i++) poke(pa[i], pd[i]);
    for (int i = 0; i < 8; i++) peek(pa[i]);
    $display("test preload ends");
    for (int i = 0; i < 17; i++) begin
      if (i == 15) begin
        // Moved pointers prove the unit follows them, not fixed values
        @(posedge clk_in);
        bank_ptr <= 4'h1;
        index_base <= 12'h300;
        @(posedge clk_in);
      end
      step(prog[i]);
      $display("test %0d ends", i);
    end
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
